/* File: mihw_map.vh */
// Register indices, field positions, reset values and vectors of the interrupt controller.
`ifndef MIHW_MAP_VH
`define MIHW_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define MIHW_IDX_TIMER_MASK 16'hFFE2
`define MIHW_IDX_SERIAL_MASK 16'hFFE3
`define MIHW_IDX_PORT0_MASK 16'hFFE4
`define MIHW_IDX_PORT12_MASK 16'hFFE5
`define MIHW_IDX_TICK_MASK 16'hFFE6
`define MIHW_IDX_CONV_MASK 16'hFFE7
`define MIHW_IDX_TIMER_PEND 16'hFFF2
`define MIHW_IDX_SERIAL_PEND 16'hFFF3
`define MIHW_IDX_PORT0_PEND 16'hFFF4
`define MIHW_IDX_PORT12_PEND 16'hFFF5
`define MIHW_IDX_TICK_PEND 16'hFFF6
`define MIHW_IDX_CONV_PEND 16'hFFF7

// ****************************************************************
// Positions in the internal flag vector
// ****************************************************************
`define MIHW_SRC_COUNT 11
`define MIHW_BIT_PTIMER0 0
`define MIHW_BIT_PTIMER1 1
`define MIHW_BIT_SERIAL 2
`define MIHW_BIT_PORT_GROUP0 3
`define MIHW_BIT_PORT_GROUP1 4
`define MIHW_BIT_PORT2 5
`define MIHW_BIT_TICK_16HZ 6
`define MIHW_BIT_TICK_8HZ 7
`define MIHW_BIT_TICK_2HZ 8
`define MIHW_BIT_TICK_1HZ 9
`define MIHW_BIT_CONVERTER 10

// ****************************************************************
// Reset values
// ****************************************************************
`define MIHW_RST_MASK 11'h000
`define MIHW_RST_PEND 11'h000

// ****************************************************************
// Low nibble of the vectors, highest priority first
// ****************************************************************
`define MIHW_VEC_WATCHDOG 4'h0
`define MIHW_VEC_PTIMER 4'h4
`define MIHW_VEC_SERIAL 4'h6
`define MIHW_VEC_PORT0 4'h8
`define MIHW_VEC_PORT12 4'hA
`define MIHW_VEC_TICK 4'hC
`define MIHW_VEC_CONVERTER 4'hE

`endif

/* File: mihw_edge.v */
// Edge detector for port pins and clock-timer taps.
`default_nettype none

module mihw_edge #(
   parameter W = 13,
   parameter [W-1:0] FALL_ONLY = {W{1'b0}}
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Levels in, one-cycle edge pulses out
   input wire [W-1:0] level,
   output wire [W-1:0] edge_pulse
);

   reg [W-1:0] prev_ff;
   reg armed_ff;

   // The first sample after reset only loads history, so a pin that
   // sits high at reset does not fake an edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= {W{1'b0}};
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= level;
         armed_ff <= 1'b1;
      end
   end

   assign edge_pulse = {W{armed_ff}} & (prev_ff ^ level) & (~FALL_ONLY | prev_ff);

endmodule

`default_nettype wire

/* File: mihw_ctrl.v */
// Interrupt controller with HALT wakeup, APB register slave and entry sequencer.
//
// Contract
// - Maskable request reaches core only with global enable and its mask both 1.
// - Accepting any interrupt clears the global enable flag.
// - Watchdog request ignores global enable, has no mask, no pending flag.
// - After reset all interrupts blocked until both stack pointers are written.
// - Writing one stack pointer blocks all interrupts until the other is written.
// - Any hardware request, watchdog included, wakes the core from HALT.
// - Source event sets pending; interrupt when pending, mask, enable all 1.
// - Writing 1 clears a pending flag, 0 keeps it; reset clears all.
// - Timer channel 1 sets bit 1, channel 0 sets bit 0 on zero.
// - Serial transfer completion sets serial pending bit 0.
// - Port edges set port group 0, port group 1 and port 2 flags.
// - Falling edges of 16, 8, 2, 1 Hz taps set tick bits 0 to 3.
// - Each pending flag has a mask bit at the matching position.
// - Mask bits are read/write, 1 enables, reset clears them.
// - Entry starts only after the current instruction has finished.
// - Entry: save flags and clear enable, push address, load vector, execute.
// - Priority watchdog, timers, serial, port0, port1/2, tick, converter; 0100H-010EH.
// - Request supplies only the four low program counter bits.
// - Unused mask bits read 0 and have no storage.
//
// The APB register port was chosen for this implementation.
`default_nettype none
`include "mihw_map.vh"

module mihw_ctrl #(
   parameter ADDR_W = 18
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Peripheral events, one-cycle pulses
   input wire ptimer0_zero,
   input wire ptimer1_zero,
   input wire serial_done,
   input wire converter_done,
   input wire watchdog_nmi,
   // Pin and tap levels
   input wire [3:0] port_group0_pins,
   input wire [3:0] port_group1_pins,
   input wire port2_pin,
   input wire [3:0] tick_taps,
   // Core control pulses
   input wire irq_on_state,
   input wire irq_off_state,
   input wire return_from_interrupt,
   input wire restore_enable,
   input wire first_stack_pointer,
   input wire second_stack_pointer,
   input wire instr_done,
   input wire halt_enter,
   // Core facing outputs
   output reg ie_flag,
   output reg irq_pending,
   output reg entry_save,
   output reg entry_push,
   output reg entry_load,
   output reg [3:0] vector_low,
   output reg halted
);

   localparam N = `MIHW_SRC_COUNT;

   // ****************************************************************
   // Entry sequencer states
   // ****************************************************************
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SAVE = 2'b01;
   localparam [1:0] ST_PUSH = 2'b10;
   localparam [1:0] ST_LOAD = 2'b11;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function [15:0] word_index;
      input [ADDR_W-1:0] a;
      begin
         word_index = a[17:2];
      end
   endfunction

   // Positions of the flag vector as they appear in each 4-bit register.
   function [3:0] reg_view;
      input [15:0] idx_low;
      input [N-1:0] v;
      begin
         case (idx_low[3:0])
            4'h2: reg_view = {2'b00, v[`MIHW_BIT_PTIMER1], v[`MIHW_BIT_PTIMER0]};
            4'h3: reg_view = {3'b000, v[`MIHW_BIT_SERIAL]};
            4'h4: reg_view = {3'b000, v[`MIHW_BIT_PORT_GROUP0]};
            4'h5: reg_view = {2'b00, v[`MIHW_BIT_PORT2], v[`MIHW_BIT_PORT_GROUP1]};
            4'h6: reg_view = v[`MIHW_BIT_TICK_1HZ:`MIHW_BIT_TICK_16HZ];
            4'h7: reg_view = {3'b000, v[`MIHW_BIT_CONVERTER]};
            default: reg_view = 4'h0;
         endcase
      end
   endfunction

   // Spreads a 4-bit write onto the flag vector; only bits with storage move.
   function [N-1:0] reg_spread;
      input [15:0] idx_low;
      input [3:0] d;
      begin
         reg_spread = {N{1'b0}};
         case (idx_low[3:0])
            4'h2: reg_spread[`MIHW_BIT_PTIMER1:`MIHW_BIT_PTIMER0] = d[1:0];
            4'h3: reg_spread[`MIHW_BIT_SERIAL] = d[0];
            4'h4: reg_spread[`MIHW_BIT_PORT_GROUP0] = d[0];
            4'h5: reg_spread[`MIHW_BIT_PORT2:`MIHW_BIT_PORT_GROUP1] = d[1:0];
            4'h6: reg_spread[`MIHW_BIT_TICK_1HZ:`MIHW_BIT_TICK_16HZ] = d;
            4'h7: reg_spread[`MIHW_BIT_CONVERTER] = d[0];
            default: reg_spread = {N{1'b0}};
         endcase
      end
   endfunction

   // ****************************************************************
   // Source events
   // ****************************************************************
   wire [12:0] edge_pulse;
   wire [N-1:0] src_event;

   mihw_edge #(
      .W(13),
      .FALL_ONLY(13'h1E00)
   ) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level({tick_taps, port2_pin, port_group1_pins, port_group0_pins}),
      .edge_pulse(edge_pulse)
   );

   assign src_event[`MIHW_BIT_PTIMER0] = ptimer0_zero;
   assign src_event[`MIHW_BIT_PTIMER1] = ptimer1_zero;
   assign src_event[`MIHW_BIT_SERIAL] = serial_done;
   assign src_event[`MIHW_BIT_PORT_GROUP0] = |edge_pulse[3:0];
   assign src_event[`MIHW_BIT_PORT_GROUP1] = |edge_pulse[7:4];
   assign src_event[`MIHW_BIT_PORT2] = edge_pulse[8];
   assign src_event[`MIHW_BIT_TICK_1HZ:`MIHW_BIT_TICK_16HZ] = edge_pulse[12:9];
   assign src_event[`MIHW_BIT_CONVERTER] = converter_done;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire [15:0] idx = word_index(paddr);
   wire is_mask = (idx >= `MIHW_IDX_TIMER_MASK) && (idx <= `MIHW_IDX_CONV_MASK);
   wire is_pend = (idx >= `MIHW_IDX_TIMER_PEND) && (idx <= `MIHW_IDX_CONV_PEND);
   wire mapped = (is_mask || is_pend) && (paddr[1:0] == 2'b00);
   wire access = psel && penable && pready;
   wire wr_mask = access && pwrite && mapped && is_mask;
   wire wr_pend = access && pwrite && mapped && is_pend;
   wire [N-1:0] wr_bits = reg_spread(idx, pwdata[3:0]);

   reg [N-1:0] mask_ff;
   reg [N-1:0] pend_ff;
   reg [N-1:0] nxt_mask;
   reg [N-1:0] nxt_pend;

   always @* begin
      nxt_mask = mask_ff;
      if (wr_mask) begin
         // Only the register addressed is touched; unused bits hold nothing.
         nxt_mask = (mask_ff & ~reg_spread(idx, 4'hF)) | wr_bits;
      end
      nxt_pend = pend_ff;
      if (wr_pend) begin
         nxt_pend = pend_ff & ~wr_bits;
      end
      // A source event in the same cycle as a clear keeps the flag set.
      nxt_pend = nxt_pend | src_event;
   end

   // One wait state: pready rises at the edge that ends the first access cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            if (mapped && is_mask) begin
               prdata <= {28'h0000000, reg_view(idx, mask_ff)};
            end else if (mapped && is_pend) begin
               prdata <= {28'h0000000, reg_view(idx, pend_ff)};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= `MIHW_RST_MASK;
         pend_ff <= `MIHW_RST_PEND;
      end else begin
         mask_ff <= nxt_mask;
         pend_ff <= nxt_pend;
      end
   end

   // ****************************************************************
   // Stack pointer pairing gate
   // ****************************************************************
   // Bit 0 means the first pointer is still missing, bit 1 the second.
   reg [1:0] sp_miss_ff;
   reg [1:0] nxt_sp_miss;

   always @* begin
      nxt_sp_miss = sp_miss_ff;
      if (first_stack_pointer && second_stack_pointer) begin
         nxt_sp_miss = 2'b00;
      end else if (first_stack_pointer) begin
         nxt_sp_miss = {(sp_miss_ff != 2'b01), 1'b0};
      end else if (second_stack_pointer) begin
         nxt_sp_miss = {1'b0, (sp_miss_ff != 2'b10)};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_miss_ff <= 2'b11;
      end else begin
         sp_miss_ff <= nxt_sp_miss;
      end
   end

   wire sp_ok = (sp_miss_ff == 2'b00);

   // ****************************************************************
   // Request and priority
   // ****************************************************************
   // The watchdog pulse is held internally until taken; it has no flag
   // software can see or clear.
   reg nmi_hold_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg nmi_taken;

   wire [N-1:0] armed = pend_ff & mask_ff;
   wire maskable_req = ie_flag && (|armed);
   wire any_req = sp_ok && (nmi_hold_ff || maskable_req);
   wire wake_req = sp_ok && (nmi_hold_ff || (|armed));

   reg [3:0] pick_vec;

   always @* begin
      if (nmi_hold_ff) begin
         pick_vec = `MIHW_VEC_WATCHDOG;
      end else if (armed[`MIHW_BIT_PTIMER0] || armed[`MIHW_BIT_PTIMER1]) begin
         pick_vec = `MIHW_VEC_PTIMER;
      end else if (armed[`MIHW_BIT_SERIAL]) begin
         pick_vec = `MIHW_VEC_SERIAL;
      end else if (armed[`MIHW_BIT_PORT_GROUP0]) begin
         pick_vec = `MIHW_VEC_PORT0;
      end else if (armed[`MIHW_BIT_PORT_GROUP1] || armed[`MIHW_BIT_PORT2]) begin
         pick_vec = `MIHW_VEC_PORT12;
      end else if (|armed[`MIHW_BIT_TICK_1HZ:`MIHW_BIT_TICK_16HZ]) begin
         pick_vec = `MIHW_VEC_TICK;
      end else begin
         pick_vec = `MIHW_VEC_CONVERTER;
      end
   end

   // ****************************************************************
   // Entry sequencer
   // ****************************************************************
   always @* begin
      nxt_state = state_ff;
      nmi_taken = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (any_req && instr_done && !halted) begin
               nxt_state = ST_SAVE;
               nmi_taken = nmi_hold_ff;
            end
         end
         ST_SAVE: begin
            nxt_state = ST_PUSH;
         end
         ST_PUSH: begin
            nxt_state = ST_LOAD;
         end
         ST_LOAD: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         nmi_hold_ff <= 1'b0;
         vector_low <= 4'h0;
         entry_save <= 1'b0;
         entry_push <= 1'b0;
         entry_load <= 1'b0;
         irq_pending <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // A new watchdog pulse in the taking cycle is kept.
         nmi_hold_ff <= watchdog_nmi || (nmi_hold_ff && !nmi_taken);
         if (state_ff == ST_IDLE && nxt_state == ST_SAVE) begin
            vector_low <= pick_vec;
         end
         entry_save <= (nxt_state == ST_SAVE);
         entry_push <= (nxt_state == ST_PUSH);
         entry_load <= (nxt_state == ST_LOAD);
         irq_pending <= any_req;
      end
   end

   // ****************************************************************
   // Global enable flag and HALT
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_flag <= 1'b0;
         halted <= 1'b0;
      end else begin
         if (state_ff == ST_IDLE && nxt_state == ST_SAVE) begin
            ie_flag <= 1'b0;
         end else if (return_from_interrupt) begin
            ie_flag <= restore_enable;
         end else if (irq_off_state) begin
            ie_flag <= 1'b0;
         end else if (irq_on_state) begin
            ie_flag <= 1'b1;
         end
         if (halted && wake_req) begin
            halted <= 1'b0;
         end else if (halt_enter) begin
            halted <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

/* File: mihw_ctrl_props.sv */
// Port assertions for the interrupt controller, bound into each controller instance.
`default_nettype none
module mihw_ctrl_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core side
   input wire logic instr_done,
   input wire logic watchdog_nmi,
   input wire logic first_stack_pointer,
   input wire logic second_stack_pointer,
   input wire logic ie_flag,
   input wire logic entry_save,
   input wire logic entry_push,
   input wire logic entry_load,
   input wire logic [3:0] vector_low,
   input wire logic halted,
   // Register bus
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sp1_ff;
   logic sp2_ff;
   logic gate_open;
   // A lone pointer written after a full pair must close the gate again.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp1_ff <= 1'b0;
         sp2_ff <= 1'b0;
      end else if (first_stack_pointer) begin
         sp1_ff <= 1'b1;
         sp2_ff <= sp2_ff & ~sp1_ff;
      end else if (second_stack_pointer) begin
         sp2_ff <= 1'b1;
         sp1_ff <= sp1_ff & ~sp2_ff;
      end
   end
   assign gate_open = sp1_ff & sp2_ff;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ie_cleared; entry_save |-> !ie_flag; endproperty
   a_ie_cleared: assert property (p_ie_cleared) else $error("ie flag set in entry");
   property p_maskable_needs_ie; entry_save && vector_low != 4'h0 |-> $past(ie_flag); endproperty
   a_maskable_needs_ie: assert property (p_maskable_needs_ie) else $error("entry without ie");
   property p_gate; entry_save |-> $past(gate_open); endproperty
   a_gate: assert property (p_gate) else $error("entry with pointer pair incomplete");
   property p_boundary; entry_save |-> $past(instr_done); endproperty
   a_boundary: assert property (p_boundary) else $error("entry inside instruction");
   property p_order; entry_save |=> entry_push ##1 entry_load; endproperty
   a_order: assert property (p_order) else $error("entry steps out of order");
   property p_vec; entry_save |-> vector_low inside {4'h0, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE}; endproperty
   a_vec: assert property (p_vec) else $error("illegal vector nibble");
   property p_vec_hold; entry_push || entry_load |-> $stable(vector_low); endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector moved during entry");
   property p_nmi; watchdog_nmi && gate_open && !halted && !entry_save && !entry_push
      |-> ##[1:12] (entry_save && vector_low == 4'h0); endproperty
   a_nmi: assert property (p_nmi) else $error("watchdog request not taken");
   property p_wake; halted && watchdog_nmi && gate_open |-> ##[1:3] !halted; endproperty
   a_wake: assert property (p_wake) else $error("watchdog did not end halt");
   property p_unused; pready && !pslverr |-> prdata[31:4] == 28'h0; endproperty
   a_unused: assert property (p_unused) else $error("unused read bits set");
endmodule
bind mihw_ctrl mihw_ctrl_chk u_chk (.*);
`default_nettype wire

/* File: mihw_core_model.sv */
// Behavioural processor core: instruction boundaries and capture of interrupt entries.
`default_nettype none
module mihw_core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Slow mode ends an instruction only every fourth cycle
   input wire logic slow,
   // Entry sequence
   input wire logic entry_save,
   input wire logic entry_load,
   input wire logic [3:0] vector_low,
   // Observations
   output logic instr_done,
   output logic [7:0] n_entry,
   output logic [3:0] last_vec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_ff;
   logic busy_ff;
   // The core shows no boundary while it pushes and jumps; busy_ff is still clear in the save cycle.
   assign instr_done = !busy_ff && (!slow || cnt_ff == 2'h3);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 2'h0;
         busy_ff <= 1'b0;
         n_entry <= 8'h00;
         last_vec <= 4'hF;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
         if (entry_save) begin
            busy_ff <= 1'b1;
         end
         if (entry_load) begin
            busy_ff <= 1'b0;
            n_entry <= n_entry + 8'h01;
            last_vec <= vector_low;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb_mcu_interrupt_and_halt_wakeup.sv */
// Self-checking testbench for the interrupt and HALT wakeup controller.
`default_nettype none
`include "mihw_map.vh"
module tb_mcu_interrupt_and_halt_wakeup;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PT0 = 0, PT1 = 1, SER = 2, CNV = 3, NMI = 4, ON = 5;
   localparam int OFF = 6, RET = 7, SP1 = 8, SP2 = 9, HLT = 10;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic port2_pin, restore_enable, instr_done, ie_flag, irq_pending, halted;
   logic entry_save, entry_push, entry_load;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] port_group0_pins, port_group1_pins, tick_taps, vector_low, last_vec;
   logic [10:0] ev;
   logic [7:0] n_entry;
   logic [3:0] mexp [6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hF, 4'h1};
   logic [3:0] vexp [5] = '{4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   mihw_ctrl DUT (.ptimer0_zero(ev[PT0]), .ptimer1_zero(ev[PT1]), .serial_done(ev[SER]),
      .converter_done(ev[CNV]), .watchdog_nmi(ev[NMI]), .irq_on_state(ev[ON]),
      .irq_off_state(ev[OFF]), .return_from_interrupt(ev[RET]), .halt_enter(ev[HLT]),
      .first_stack_pointer(ev[SP1]), .second_stack_pointer(ev[SP2]), .*);
   mihw_core_model core (.*);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report;
      end
   end
   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {28'h0000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees pready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int i);
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
   endtask
   task automatic quiet(input string nm);
      logic [7:0] c0;
      c0 = n_entry;
      repeat (12) @(posedge pclk);
      chk(nm, {24'h0, n_entry}, {24'h0, c0});
   endtask
   task automatic take(input logic [3:0] v);
      logic [7:0] c0;
      c0 = n_entry;
      for (int n = 0; n < 40 && n_entry === c0; n++) @(posedge pclk);
      chk("entry taken", {24'h0, n_entry - c0}, 32'h1);
      chk("vector", {28'h0, last_vec}, {28'h0, v});
      chk("ie after entry", {31'h0, ie_flag}, 32'h0);
   endtask
   task automatic wake;
      for (int n = 0; n < 10 && halted !== 1'b0; n++) @(posedge pclk);
      chk("halted", {31'h0, halted}, 32'h0);
   endtask
   task automatic final_report;
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 16'(`MIHW_IDX_TIMER_MASK + i), 4'h0);
         chk("mask reset", rd, 32'h0);
         apb(1'b0, 16'(`MIHW_IDX_TIMER_PEND + i), 4'h0);
         chk("pending reset", rd, 32'h0);
         apb(1'b1, 16'(`MIHW_IDX_TIMER_MASK + i), 4'hF);
         apb(1'b0, 16'(`MIHW_IDX_TIMER_MASK + i), 4'h0);
         chk("mask bits", rd, {28'h0, mexp[i]});
      end
      apb(1'b0, 16'hFFE8, 4'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
   endtask
   task automatic t_events;
      pulse(PT0);
      pulse(PT1);
      pulse(SER);
      pulse(CNV);
      port_group0_pins <= 4'h1;
      port_group1_pins <= 4'h2;
      port2_pin <= 1'b1;
      tick_taps <= 4'hF;
      repeat (4) @(posedge pclk);
      apb(1'b0, `MIHW_IDX_TICK_PEND, 4'h0);
      chk("tick rising", rd, 32'h0);
      tick_taps <= 4'h0;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 16'(`MIHW_IDX_TIMER_PEND + i), 4'h0);
         chk("pending set", rd, {28'h0, mexp[i]});
      end
      chk("request without ie", {31'h0, irq_pending}, 32'h0);
      apb(1'b1, `MIHW_IDX_TIMER_PEND, 4'h0);
      apb(1'b0, `MIHW_IDX_TIMER_PEND, 4'h0);
      chk("write zero keeps", rd, 32'h3);
      apb(1'b1, `MIHW_IDX_TIMER_PEND, 4'h1);
      apb(1'b0, `MIHW_IDX_TIMER_PEND, 4'h0);
      chk("write one clears", rd, 32'h2);
   endtask
   task automatic t_gate;
      restore_enable <= 1'b1;
      apb(1'b1, `MIHW_IDX_TIMER_MASK, 4'h0);
      pulse(ON);
      pulse(PT0);
      chk("ie set", {31'h0, ie_flag}, 32'h1);
      quiet("entry before pointers");
      pulse(SP1);
      quiet("entry with one pointer");
      pulse(SP2);
      for (int i = 0; i < 5; i++) begin
         take(vexp[i]);
         apb(1'b1, 16'(`MIHW_IDX_TIMER_PEND + i + 1), 4'hF);
         pulse(RET);
      end
      apb(1'b1, `MIHW_IDX_TIMER_MASK, 4'h3);
      take(4'h4);
      apb(1'b1, `MIHW_IDX_TIMER_PEND, 4'hF);
      pulse(RET);
      quiet("entry after service");
   endtask
   task automatic t_pair;
      pulse(SP1);
      pulse(PT1);
      quiet("entry after lone pointer");
      pulse(SP1);
      quiet("entry after same pointer twice");
      slow <= 1'b1;
      pulse(SP2);
      repeat (2) @(posedge pclk);
      chk("request", {31'h0, irq_pending}, 32'h1);
      take(4'h4);
      slow <= 1'b0;
      apb(1'b1, `MIHW_IDX_TIMER_PEND, 4'hF);
      pulse(RET);
   endtask
   task automatic t_nmi_halt;
      pulse(OFF);
      pulse(NMI);
      take(4'h0);
      pulse(HLT);
      // The flag is launched by the edge that ends the pulse; look one edge later.
      @(posedge pclk);
      chk("halt entered", {31'h0, halted}, 32'h1);
      pulse(CNV);
      wake;
      quiet("entry with ie clear");
      apb(1'b1, `MIHW_IDX_CONV_PEND, 4'hF);
      pulse(HLT);
      pulse(NMI);
      wake;
      take(4'h0);
   endtask
   initial begin
      {psel, penable, pwrite, slow, port2_pin, restore_enable} = '0;
      {port_group0_pins, port_group1_pins, tick_taps} = '0;
      paddr = '0;
      pwdata = '0;
      ev = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_events;
      t_gate;
      t_pair;
      t_nmi_halt;
      final_report;
   end
endmodule
`default_nettype wire
